// file: core/pic_core.v
// prioritized interrupt controller with wishbone register slave and forced-call sequencer
`timescale 1ns/10ps
`include "pic_regs.vh"

module pic_core (
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [9:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output wire [31:0] dat_o,
    output wire ack_o,
    // peripheral events, one-cycle pulses, bit index = source number
    input wire [17:0] src_event_i,
    // core sequencing
    input wire instr_boundary_i,
    input wire return_from_interrupt_i,
    output wire forced_long_call_o,
    output wire call_done_o,
    output wire [7:0] vector_o,
    output wire [4:0] source_o,
    output wire [3:0] in_service_o
);

    // ------------------------------------------------------------
    // state codes
    // ------------------------------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_CALL = 1'b1;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // group of each source
    function [2:0] grp_of;
        input [4:0] src;
        begin
            case (src)
                5'd0, 5'd16, 5'd8: grp_of = 3'd0;
                5'd1, 5'd9, 5'd6: grp_of = 3'd1;
                5'd2, 5'd10, 5'd7: grp_of = 3'd2;
                5'd11, 5'd14: grp_of = 3'd3;
                5'd4, 5'd12, 5'd15: grp_of = 3'd4;
                default: grp_of = 3'd5;
            endcase
        end
    endfunction

    // source at each polling position
    function [4:0] poll_src;
        input [4:0] pos;
        begin
            case (pos)
                5'd0: poll_src = 5'd0;
                5'd1: poll_src = 5'd16;
                5'd2: poll_src = 5'd8;
                5'd3: poll_src = 5'd1;
                5'd4: poll_src = 5'd9;
                5'd5: poll_src = 5'd2;
                5'd6: poll_src = 5'd10;
                5'd7: poll_src = 5'd3;
                5'd8: poll_src = 5'd11;
                5'd9: poll_src = 5'd4;
                5'd10: poll_src = 5'd12;
                5'd11: poll_src = 5'd5;
                5'd12: poll_src = 5'd13;
                5'd13: poll_src = 5'd6;
                5'd14: poll_src = 5'd7;
                5'd15: poll_src = 5'd14;
                5'd16: poll_src = 5'd15;
                default: poll_src = 5'd17;
            endcase
        end
    endfunction

    // register index hit for a write
    function wr_hit;
        input [7:0] idx;
        input [7:0] want;
        input en;
        begin
            wr_hit = en && (idx == want);
        end
    endfunction

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    reg ack_q; // bus answer, one cycle
    reg [7:0] rdata_q; // registered read data
    reg [7:0] rdata_d; // read mux
    reg [7:0] arr_q; // adc / rx / radio fifo error flags + detect bits
    reg [7:0] arr_d;
    reg [1:0] aes_q; // two aes pending flags
    reg [1:0] aes_d;
    reg [1:0] rad_q; // two radio pending flags
    reg [1:0] rad_d;
    reg [7:0] tds_q; // timers / dma / sleep / port0 flags
    reg [7:0] tds_d;
    reg [4:0] wps_q; // watchdog / ports / serial tx / two-wire flags
    reg [4:0] wps_d;
    reg [7:0] en0_q; // enable_register_zero incl. global enable
    reg [5:0] en1_q; // enable register one
    reg [5:0] en2_q; // enable register two
    reg [5:0] plo_q; // group_level_low_bit per group
    reg [5:0] phi_q; // group_level_high_bit per group
    reg state_q; // sequencer state
    reg [2:0] cnt_q; // call cycles left
    reg [4:0] src_q; // latched winning source
    reg [1:0] lvl_q; // latched winning level
    reg [7:0] vec_q; // vector to core
    reg [3:0] svc_q; // one bit per level in service
    reg done_q; // vectoring pulse
    wire [7:0] idx; // register index from byte address
    wire bus_req; // request present
    wire wr_en; // write commits this edge
    wire [7:0] wb; // written byte
    wire [17:0] pend; // pending flag per source
    wire [17:0] en; // enable per source
    wire [17:0] req; // enabled and globally allowed
    wire [17:0] hwclr; // hardware clear on vectoring
    wire [1:0] lvl [0:17]; // level per source
    wire svc_any; // some service running
    reg [1:0] svc_lvl; // level of running service
    reg [3:0] svc_top; // highest service bit
    reg found; // winner exists
    reg [4:0] win_src; // winning source
    reg [1:0] win_lvl; // winning level
    reg [4:0] s; // loop scratch
    integer k; // arbitration loop index
    integer j; // service level loop index

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    assign idx = adr_i[9:2];
    assign bus_req = cyc_i && stb_i;
    assign wr_en = bus_req && we_i && ack_q && sel_i[0];
    assign wb = dat_i[7:0];

    // ack one cycle after request, dropped the next cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            ack_q <= bus_req && !ack_q;
            if (bus_req && !ack_q) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // read mux, unmapped reads zero
    always @* begin
        if (idx == `PIC_IDX_FLAGS_ARR) begin
            rdata_d = arr_q;
        end else if (idx == `PIC_IDX_AES) begin
            rdata_d = {6'h00, aes_q};
        end else if (idx == `PIC_IDX_RADIO) begin
            rdata_d = {6'h00, rad_q};
        end else if (idx == `PIC_IDX_FLAGS_TDS) begin
            rdata_d = tds_q;
        end else if (idx == `PIC_IDX_FLAGS_WPS) begin
            rdata_d = {3'h0, wps_q};
        end else if (idx == `PIC_IDX_EN0) begin
            rdata_d = en0_q;
        end else if (idx == `PIC_IDX_EN1) begin
            rdata_d = {2'h0, en1_q};
        end else if (idx == `PIC_IDX_EN2) begin
            rdata_d = {2'h0, en2_q};
        end else if (idx == `PIC_IDX_PRIO_LO) begin
            rdata_d = {2'h0, plo_q};
        end else if (idx == `PIC_IDX_PRIO_HI) begin
            rdata_d = {2'h0, phi_q};
        end else if (idx == `PIC_IDX_STATUS) begin
            rdata_d = {3'h0, state_q, svc_q};
        end else begin
            rdata_d = 8'h00;
        end
    end

    assign dat_o = {24'h000000, rdata_q};
    assign ack_o = ack_q;

    // ------------------------------------------------------------
    // flag registers
    // ------------------------------------------------------------
    assign hwclr = done_q ? (`PIC_HWCLR_MASK & (18'h00001 << src_q)) : 18'h00000;

    // next flag values: software write, then hardware clear, then event set wins
    always @* begin
        arr_d = arr_q;
        if (wr_hit(idx, `PIC_IDX_FLAGS_ARR, wr_en)) begin
            arr_d = wb & `PIC_ARR_WMASK;
        end
        arr_d[`PIC_ARR_RADIO_FIFO_ERROR_SOURCE] = (arr_d[`PIC_ARR_RADIO_FIFO_ERROR_SOURCE] & ~hwclr[0]) | src_event_i[0];
        arr_d[`PIC_ARR_ADC] = (arr_d[`PIC_ARR_ADC] & ~hwclr[1]) | src_event_i[1];
        arr_d[`PIC_ARR_RX] = (arr_d[`PIC_ARR_RX] & ~hwclr[2]) | src_event_i[2];
        aes_d = aes_q;
        if (wr_hit(idx, `PIC_IDX_AES, wr_en)) begin
            aes_d = wb[1:0];
        end
        aes_d = aes_d | {2{src_event_i[4]}};
        rad_d = rad_q;
        if (wr_hit(idx, `PIC_IDX_RADIO, wr_en)) begin
            rad_d = wb[1:0];
        end
        rad_d = rad_d | {2{src_event_i[16]}};
        tds_d = tds_q;
        if (wr_hit(idx, `PIC_IDX_FLAGS_TDS, wr_en)) begin
            tds_d = wb;
        end
        tds_d[4:1] = (tds_d[4:1] & ~hwclr[12:9]) | src_event_i[12:9];
        tds_d[0] = tds_d[0] | src_event_i[8];
        tds_d[`PIC_TDS_PORT0] = tds_d[`PIC_TDS_PORT0] | src_event_i[13];
        tds_d[`PIC_TDS_SLEEP] = tds_d[`PIC_TDS_SLEEP] | src_event_i[5];
        wps_d = wps_q;
        if (wr_hit(idx, `PIC_IDX_FLAGS_WPS, wr_en)) begin
            wps_d = wb[4:0] & `PIC_WPS_WMASK;
        end
        wps_d = wps_d | {src_event_i[17], src_event_i[15], src_event_i[14], src_event_i[7], src_event_i[6]};
    end

    // flag storage
    always @(posedge clk_i) begin
        if (rst_i) begin
            arr_q <= `PIC_ARR_RESET;
            aes_q <= 2'h0;
            rad_q <= 2'h0;
            tds_q <= 8'h00;
            wps_q <= 5'h00;
        end else begin
            arr_q <= arr_d;
            aes_q <= aes_d;
            rad_q <= rad_d;
            tds_q <= tds_d;
            wps_q <= wps_d;
        end
    end

    // ------------------------------------------------------------
    // enable and priority registers
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            en0_q <= 8'h00;
            en1_q <= 6'h00;
            en2_q <= 6'h00;
            plo_q <= 6'h00;
            phi_q <= 6'h00;
        end else begin
            if (wr_hit(idx, `PIC_IDX_EN0, wr_en)) begin
                en0_q <= wb & `PIC_EN0_WMASK;
            end
            if (wr_hit(idx, `PIC_IDX_EN1, wr_en)) begin
                en1_q <= wb[5:0] & `PIC_EN_WMASK;
            end
            if (wr_hit(idx, `PIC_IDX_EN2, wr_en)) begin
                en2_q <= wb[5:0] & `PIC_EN_WMASK;
            end
            if (wr_hit(idx, `PIC_IDX_PRIO_LO, wr_en)) begin
                plo_q <= wb[5:0] & `PIC_PRIO_WMASK;
            end
            if (wr_hit(idx, `PIC_IDX_PRIO_HI, wr_en)) begin
                phi_q <= wb[5:0] & `PIC_PRIO_WMASK;
            end
        end
    end

    // ------------------------------------------------------------
    // request mapping
    // ------------------------------------------------------------
    assign pend = {wps_q[4], |rad_q, wps_q[3], wps_q[2], tds_q[`PIC_TDS_PORT0], tds_q[4:1], tds_q[0],
                   wps_q[1], wps_q[0], tds_q[`PIC_TDS_SLEEP], |aes_q, 1'b0,
                   arr_q[`PIC_ARR_RX], arr_q[`PIC_ARR_ADC], arr_q[`PIC_ARR_RADIO_FIFO_ERROR_SOURCE]};
    assign en = {en2_q[5], en2_q[0], en2_q[4], en2_q[3], en1_q[5], en1_q[4:1], en1_q[0],
                 en2_q[2], en2_q[1], en0_q[5] | tds_q[`PIC_TDS_FORCE], en0_q[4], 1'b0,
                 en0_q[2:0]};
    assign req = pend & en & {18{en0_q[`PIC_EN0_GLOBAL]}};

    // level of each source from its group bits
    genvar g;
    generate
        for (g = 0; g < `PIC_NUM_SRC; g = g + 1) begin : gen_lvl
            localparam [4:0] SRC_NUM = g; // source number of this lane
            assign lvl[g] = {phi_q[grp_of(SRC_NUM)], plo_q[grp_of(SRC_NUM)]};
        end
    endgenerate
    // ------------------------------------------------------------
    // running service level
    // ------------------------------------------------------------
    assign svc_any = |svc_q;
    always @* begin
        svc_lvl = 2'd0;
        svc_top = 4'h0;
        for (j = 0; j < 4; j = j + 1) begin
            if (svc_q[j]) begin
                svc_lvl = j[1:0];
                svc_top = 4'h1 << j;
            end
        end
    end
    // ------------------------------------------------------------
    // arbitration: highest level above service, poll order breaks ties
    // ------------------------------------------------------------
    always @* begin
        found = 1'b0;
        win_src = 5'd0;
        win_lvl = 2'd0;
        s = 5'd0;
        for (k = 0; k < `PIC_NUM_SRC; k = k + 1) begin
            s = poll_src(k[4:0]);
            if (req[s] && (!svc_any || lvl[s] > svc_lvl) && (!found || lvl[s] > win_lvl)) begin
                found = 1'b1;
                win_src = s;
                win_lvl = lvl[s];
            end
        end
    end

    // ------------------------------------------------------------
    // forced-call sequencer
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            cnt_q <= 3'h0;
            src_q <= 5'd0;
            lvl_q <= 2'd0;
            vec_q <= 8'h00;
            svc_q <= 4'h0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (return_from_interrupt_i) begin
                svc_q <= svc_q & ~svc_top;
            end
            case (state_q)
                ST_IDLE: begin
                    // detect cycle: decision fixed here even if global enable drops next
                    if (instr_boundary_i && found) begin
                        state_q <= ST_CALL;
                        cnt_q <= `PIC_CALL_CYCLES;
                        src_q <= win_src;
                        lvl_q <= win_lvl;
                        vec_q <= {win_src, `PIC_VEC_LOW};
                    end
                end
                ST_CALL: begin
                    cnt_q <= cnt_q - 3'h1;
                    if (cnt_q == 3'h1) begin
                        state_q <= ST_IDLE;
                        done_q <= 1'b1;
                        svc_q <= (return_from_interrupt_i ? (svc_q & ~svc_top) : svc_q) | (4'h1 << lvl_q);
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign forced_long_call_o = (state_q == ST_CALL);
    assign call_done_o = done_q;
    assign vector_o = vec_q;
    assign source_o = src_q;
    assign in_service_o = svc_q;

endmodule

// file: core/pic_regs.vh
// register indices, field positions, reset values and timing counts of the interrupt controller
`ifndef PIC_REGS_VH
`define PIC_REGS_VH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define PIC_IDX_FLAGS_ARR 8'h88
`define PIC_IDX_AES 8'h98
`define PIC_IDX_EN2 8'h9A
`define PIC_IDX_RADIO 8'h9B
`define PIC_IDX_EN0 8'hA8
`define PIC_IDX_PRIO_LO 8'hA9
`define PIC_IDX_EN1 8'hB8
`define PIC_IDX_PRIO_HI 8'hB9
`define PIC_IDX_FLAGS_TDS 8'hC0
`define PIC_IDX_FLAGS_WPS 8'hE8
`define PIC_IDX_STATUS 8'hF0

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PIC_ARR_ADC 5
`define PIC_ARR_RX 3
`define PIC_ARR_DET_B 2
`define PIC_ARR_RADIO_FIFO_ERROR_SOURCE 1
`define PIC_ARR_DET_A 0
`define PIC_EN0_GLOBAL 7
`define PIC_TDS_SLEEP 7
`define PIC_TDS_FORCE 6
`define PIC_TDS_PORT0 5
`define PIC_STAT_BUSY 4

// ------------------------------------------------------------
// reset values and masks
// ------------------------------------------------------------
`define PIC_ARR_RESET 8'h05
`define PIC_ARR_WMASK 8'h2F
`define PIC_EN0_WMASK 8'hBF
`define PIC_EN_WMASK 6'h3F
`define PIC_PRIO_WMASK 6'h3F
`define PIC_WPS_WMASK 5'h1F
`define PIC_HWCLR_MASK 18'h01E07

// ------------------------------------------------------------
// vector layout and timing
// ------------------------------------------------------------
`define PIC_VEC_LOW 3'h3
`define PIC_CALL_CYCLES 3'h6
`define PIC_NUM_SRC 18

`endif

// file: test/pic_core_asserts.sv
// port-level assertion checker for the interrupt controller
`timescale 1ns/10ps
module pic_core_chk (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire ack_o,
    input wire instr_boundary_i,
    input wire return_from_interrupt_i,
    input wire forced_long_call_o,
    input wire call_done_o,
    input wire [7:0] vector_o,
    input wire [4:0] source_o,
    input wire [3:0] in_service_o
);
    // ----------------------------------------
    // helper state
    // ----------------------------------------
    reg [3:0] svc_q; // levels in service when a call starts
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // capture the service levels at call start
    always @(posedge clk_i) begin
        if (rst_i) begin
            svc_q <= 4'h0;
        end else if ($rose(forced_long_call_o)) begin
            svc_q <= in_service_o;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    sequence s_call_body;
        forced_long_call_o [*6];
    endsequence
    sequence s_call_end;
        !forced_long_call_o && call_done_o;
    endsequence
    property p_call_len;
        $rose(forced_long_call_o) |-> s_call_body ##1 s_call_end;
    endproperty
    a_call_len: assert property (p_call_len)
        else $error("forced call length wrong");
    property p_call_cause;
        $rose(forced_long_call_o) |-> $past(instr_boundary_i);
    endproperty
    a_call_cause: assert property (p_call_cause)
        else $error("call started without instruction boundary");
    property p_vector;
        call_done_o |-> vector_o == {source_o, 3'h3};
    endproperty
    a_vector: assert property (p_vector)
        else $error("vector does not match source");
    property p_src_range;
        forced_long_call_o |-> source_o != 5'h03 && source_o < 5'h12;
    endproperty
    a_src_range: assert property (p_src_range)
        else $error("call to unused source");
    property p_nest;
        call_done_o |-> ##[0:1] (in_service_o > svc_q && (in_service_o & svc_q) == svc_q
            && (in_service_o ^ svc_q) > svc_q);
    endproperty
    a_nest: assert property (p_nest)
        else $error("nested call not at a strictly higher level");
    property p_return;
        return_from_interrupt_i && in_service_o != 4'h0 && !call_done_o
            |=> in_service_o < $past(in_service_o) && $onehot(in_service_o ^ $past(in_service_o))
            && (in_service_o ^ $past(in_service_o)) > in_service_o;
    endproperty
    a_return: assert property (p_return)
        else $error("return did not drop the top service level");
    property p_ack_reply;
        cyc_i && stb_i && !ack_o |=> ack_o;
    endproperty
    a_ack_reply: assert property (p_ack_reply)
        else $error("bus request not acknowledged next cycle");
    property p_ack_pulse;
        ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("acknowledge longer than one cycle");
endmodule

bind pic_core pic_core_chk pic_core_chk_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .instr_boundary_i(instr_boundary_i), .return_from_interrupt_i(return_from_interrupt_i),
    .forced_long_call_o(forced_long_call_o), .call_done_o(call_done_o),
    .vector_o(vector_o), .source_o(source_o), .in_service_o(in_service_o)
);

// file: test/pic_cpu_model.sv
// behavioural core model: instruction boundaries and return pulses
`timescale 1ns/10ps
module pic_cpu_model (
    input wire clk_i,
    input wire rst_i,
    input wire [3:0] gap_i,
    input wire ret_req_i,
    input wire forced_long_call_i,
    output reg instr_boundary_o,
    output reg return_o
);
    reg [3:0] cnt_q; // cycles since last boundary
    // core is busy during a forced call; gap sets the pace, zero stalls
    always @(posedge clk_i) begin
        return_o <= ret_req_i && !rst_i;
        if (rst_i || forced_long_call_i || gap_i == 4'h0) begin
            instr_boundary_o <= 1'b0;
            cnt_q <= 4'h0;
        end else if (cnt_q + 4'h1 >= gap_i) begin
            instr_boundary_o <= 1'b1;
            cnt_q <= 4'h0;
        end else begin
            instr_boundary_o <= 1'b0;
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

// file: test/tb_pic_core.sv
// self-checking bench for the interrupt controller
`timescale 1ns/10ps
`include "pic_regs.vh"
module tb_pic_core;
    // ----------------------------------------
    // stimulus, wires and tables
    // ----------------------------------------
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg cyc = 1'b0, stb = 1'b0, we = 1'b0, ret_req = 1'b0;
    reg [9:0] adr = 10'h000;
    reg [3:0] sel = 4'h0;
    reg [31:0] dat = 32'h0;
    reg [17:0] ev = 18'h0;
    reg [3:0] gap = 4'h1;
    wire [31:0] dat_o;
    wire ack_o, bnd, rti, flc, done;
    wire [7:0] vec;
    wire [4:0] src;
    wire [3:0] svc;
    integer failures = 0, n_compared = 0, n_calls = 0, c, lv, p, k;
    reg [7:0] rd, lat, lo8, hi8;
    reg [17:0] hw = 18'h01E07; // flags cleared on vectoring
    // flag register index and mask per source
    reg [15:0] fmap [0:17] = '{16'h8802, 16'h8820, 16'h8808, 16'h0000, 16'h9803, 16'hC080, 16'hE801,
        16'hE802, 16'hC001, 16'hC002, 16'hC004, 16'hC008, 16'hC010, 16'hC020, 16'hE804, 16'hE808,
        16'h9B03, 16'hE810};
    integer grp [0:17] = '{0, 1, 2, 0, 4, 5, 1, 2, 0, 1, 2, 3, 4, 5, 3, 4, 0, 5};
    integer ord [0:16] = '{0, 16, 8, 1, 9, 2, 10, 11, 4, 12, 5, 13, 6, 7, 14, 15, 17};
    reg [7:0] zl [0:9] = '{8'h98, 8'h9B, 8'hA9, 8'hB9, 8'hE8, 8'hC0, 8'hA8, 8'hB8, 8'h9A, 8'h10};

    pic_core pic_core_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .src_event_i(ev),
        .instr_boundary_i(bnd), .return_from_interrupt_i(rti), .forced_long_call_o(flc),
        .call_done_o(done), .vector_o(vec), .source_o(src), .in_service_o(svc));
    pic_cpu_model pic_cpu_model_i (.clk_i(clk_i), .rst_i(rst_i), .gap_i(gap), .ret_req_i(ret_req),
        .forced_long_call_i(flc), .instr_boundary_o(bnd), .return_o(rti));

    // clock and call counter
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) if (done === 1'b1) n_calls <= n_calls + 1;
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task fail(input string m);
        failures = failures + 1;
        $display("MISMATCH at %0t: %0s", $time, m);
    endtask
    task chk8(input [7:0] got, input [7:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) fail($sformatf("got %h want %h", got, exp));
    endtask
    // one classic bus cycle, read byte lands in rd
    task wb(input w, input [7:0] idx, input [7:0] d, input [3:0] s);
        integer n;
        begin
            @(posedge clk_i);
            {cyc, stb, we, sel} <= {1'b1, 1'b1, w, s};
            adr <= {idx, 2'b00};
            dat <= {24'h0, d};
            n = 0;
            do begin
                @(posedge clk_i);
                n = n + 1;
            end while (ack_o !== 1'b1 && n < 20);
            rd = dat_o[7:0];
            {cyc, stb} <= 2'b00;
            if (ack_o !== 1'b1) fail("no bus acknowledge");
        end
    endtask
    task wr(input [7:0] idx, input [7:0] d);
        wb(1'b1, idx, d, 4'hF);
    endtask
    task rdc(input [7:0] idx, input [7:0] exp);
        wb(1'b0, idx, 8'h00, 4'hF);
        chk8(rd, exp);
    endtask
    task evt(input [17:0] m);
        @(posedge clk_i);
        ev <= m;
        @(posedge clk_i);
        ev <= 18'h0;
    endtask
    task ret;
        @(posedge clk_i);
        ret_req <= 1'b1;
        @(posedge clk_i);
        ret_req <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    // wait for a call, count its latency, check source and vector
    task chk_call(input [4:0] s);
        lat = 8'h00;
        do begin
            @(posedge clk_i);
            #1;
            lat = lat + 8'h01;
        end while (done !== 1'b1 && lat < 8'hC8);
        if (done !== 1'b1) fail("no forced call");
        chk8({3'h0, src}, {3'h0, s});
        chk8(vec, {s, 3'h3});
    endtask
    // service routine: check flag state, clear software flags
    task isr(input [4:0] s);
        chk_call(s);
        wb(1'b0, fmap[s][15:8], 8'h00, 4'hF);
        chk8({7'h0, |(rd & fmap[s][7:0])}, {7'h0, !hw[s]});
        if (!hw[s]) wr(fmap[s][15:8], rd & ~fmap[s][7:0]);
    endtask
    task tdone(input string m);
        $display("test %0s done", m);
    endtask
    task wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(8'h88, 8'h05);
        for (p = 0; p < 10; p = p + 1) rdc(zl[p], 8'h00);
        wb(1'b1, 8'hA9, 8'h3F, 4'h0);
        rdc(8'hA9, 8'h00);
        wr(8'h88, 8'h00);
        rdc(8'h88, 8'h00);
        wr(8'h88, 8'h05);
        tdone("reset values");
        evt(18'h3FFF7);
        rdc(8'h88, 8'h2F);
        rdc(8'h98, 8'h03);
        rdc(8'h9B, 8'h03);
        rdc(8'hC0, 8'hBF);
        rdc(8'hE8, 8'h1F);
        tdone("flags");
        // all sources pending, served by level then polling order
        for (c = 0; c < 2; c = c + 1) begin
            lo8 = c ? 8'h1A : 8'h00;
            hi8 = c ? 8'h0C : 8'h00;
            wr(8'hA8, 8'h37);
            evt(18'h3FFF7);
            wr(8'hA9, lo8);
            wr(8'hB9, hi8);
            wr(8'hB8, 8'h3F);
            wr(8'h9A, 8'h3F);
            k = n_calls;
            repeat (10) @(posedge clk_i);
            chk8(8'(n_calls - k), 8'h00);
            wr(8'hA8, 8'hB7);
            for (lv = 3; lv >= 0; lv = lv - 1) begin
                for (p = 0; p < 17; p = p + 1) begin
                    if ({hi8[grp[ord[p]]], lo8[grp[ord[p]]]} == lv) begin
                        isr(ord[p]);
                        ret;
                    end
                end
            end
        end
        tdone("order");
        evt(18'h1 << 9);
        isr(9);
        k = n_calls;
        evt(18'h3000);
        repeat (20) @(posedge clk_i);
        chk8(8'(n_calls - k), 8'h00);
        evt(18'h1 << 10);
        isr(10);
        evt(18'h1 << 14);
        isr(14);
        chk8({4'h0, svc}, 8'h0E);
        rdc(8'hF0, 8'h0E);
        ret;
        ret;
        chk8({4'h0, svc}, 8'h02);
        ret;
        isr(12);
        ret;
        isr(13);
        ret;
        tdone("nesting");
        wr(8'hA8, 8'h80);
        evt(18'h1 << 5);
        k = n_calls;
        repeat (20) @(posedge clk_i);
        chk8(8'(n_calls - k), 8'h00);
        wb(1'b0, 8'hC0, 8'h00, 4'hF);
        wr(8'hC0, rd | 8'h40);
        isr(5);
        wr(8'hC0, 8'h00);
        ret;
        tdone("force enable");
        wr(8'hA8, 8'hB7);
        evt(18'h1);
        isr(0);
        chk8(lat, 8'h07);
        ret;
        @(posedge clk_i) gap <= 4'h6;
        evt(18'h1 << 1);
        isr(1);
        ret;
        @(posedge clk_i) gap <= 4'h1;
        wr(8'h98, 8'h02);
        isr(4);
        ret;
        wr(8'h9B, 8'h01);
        isr(16);
        ret;
        tdone("latency");
        wrap_up;
    end
    // hang guard
    initial begin
        #(20 * 20000);
        fail("watchdog expired");
        wrap_up;
    end
endmodule
